// ### design/vrcfl_map.svh
// Purpose: offsets, field positions, reset values and timing counts of the control and fault block
// Assumes: 25 MHz mclk, millivolt-coded analog samples
// Notes: definitions only
`ifndef VRCFL_MAP_SVH
`define VRCFL_MAP_SVH

// register offsets
`define VRCFL_REG_CTRL 4'h0
`define VRCFL_REG_STAGE_FAULT_CONFIG 4'h1
`define VRCFL_REG_UNDERVOLTAGE_LOCKOUT_SELECT_CONFIG 4'h2
`define VRCFL_REG_BOOT_VOLTAGE 4'h3
`define VRCFL_REG_OUTPUT_VOLTAGE_TARGET 4'h4
`define VRCFL_REG_STATUS 4'h5
`define VRCFL_REG_TEMP_LO 4'h6
`define VRCFL_REG_TEMP_HI 4'h7
`define VRCFL_REG_DAC_CODE 4'h8

// field positions and reset values
`define VRCFL_CTRL_COARSE_BIT 0
`define VRCFL_FAULT_DISABLE_BIT 3
`define VRCFL_CTRL_RST 8'h00
`define VRCFL_STAGE_FAULT_RST 8'h00
`define VRCFL_UNDERVOLTAGE_LOCKOUT_SEL_RST 2'h1
`define VRCFL_BOOT_VOLTAGE_RST 8'h97

// voltage code table
`define VRCFL_FINE_BASE_MV 16'h00FA
`define VRCFL_FINE_STEP_MV 16'h0005
`define VRCFL_COARSE_BASE_MV 16'h01F4
`define VRCFL_COARSE_STEP_MV 16'h000A
`define VRCFL_COARSE_LAST_CODE 8'hC9

// thermal sense, millivolts and tenths of a degree
`define VRCFL_TEMP_OFFSET_MV 12'h258
`define VRCFL_TEMP_MAX_TENTHS 16'h04FF
`define VRCFL_STAGE_FAULT_MV 12'h9C4

// input lockout thresholds in millivolts, on / off
`define VRCFL_UVLO0_ON_MV 16'h1194
`define VRCFL_UVLO0_OFF_MV 16'h0DAC
`define VRCFL_UVLO1_ON_MV 16'h1C52
`define VRCFL_UVLO1_OFF_MV 16'h186A
`define VRCFL_UVLO2_ON_MV 16'h1EDC
`define VRCFL_UVLO2_OFF_MV 16'h1AF4
`define VRCFL_UVLO3_ON_MV 16'h283C
`define VRCFL_UVLO3_OFF_MV 16'h2454

// timing
`define VRCFL_CLK_MHZ 25
`define VRCFL_BOOT_RETURN_MIN_NS 1000
`define VRCFL_BOOT_RETURN_CYCLES ((`VRCFL_BOOT_RETURN_MIN_NS * `VRCFL_CLK_MHZ) / 1000 + 1)
`define VRCFL_SLEW_TICK0 16'h0019
`define VRCFL_SLEW_TICK1 16'h0032
`define VRCFL_SLEW_TICK2 16'h0064
`define VRCFL_SLEW_TICK3 16'h00C8

`endif

// ### design/vrcfl_pkg.sv
// Purpose: types of the control and fault block
// Assumes: nothing
// Notes: constants live in vrcfl_map.svh
package vrcfl_pkg;
	typedef enum logic [1:0] {ST_OFF, ST_SOFTSTART, ST_RUN} vrcfl_state_t;
endpackage : vrcfl_pkg

// ### design/vrcfl_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: single mclk domain
// Notes: first stage is read only by the second
`timescale 1ns/10ps
module vrcfl_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q, stage_q, prev_q;

	// a word is passed on only once two settled samples agree, so a multi-bit sample caught mid-change is dropped
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			meta_q <= '0;
			stage_q <= '0;
			prev_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			stage_q <= meta_q;
			prev_q <= stage_q;
			if (stage_q == prev_q) begin
				q <= stage_q;
			end
		end
	end
endmodule : vrcfl_sync

// ### design/vrcfl_code_decode.sv
// Purpose: voltage code to millivolts in either step mode
// Assumes: code 00 means no output
// Notes: purely combinational
`timescale 1ns/10ps
`include "vrcfl_map.svh"
module vrcfl_code_decode (
	// code in
	input wire logic [7:0] voltage_code,
	input wire logic coarse_mode,
	// result
	output logic [15:0] millivolts,
	output logic valid
);
	logic [15:0] idx;

	always_comb begin
		idx = {8'h00, voltage_code} - 16'h0001;
		millivolts = 16'h0000;
		valid = 1'b0;
		if (voltage_code != 8'h00) begin
			if (coarse_mode) begin
				if (voltage_code <= `VRCFL_COARSE_LAST_CODE) begin
					valid = 1'b1;
					millivolts = 16'(`VRCFL_COARSE_BASE_MV + idx * `VRCFL_COARSE_STEP_MV);
				end
			end else begin
				valid = 1'b1;
				millivolts = 16'(`VRCFL_FINE_BASE_MV + idx * `VRCFL_FINE_STEP_MV);
			end
		end
	end
endmodule : vrcfl_code_decode

// ### design/vrcfl_top.sv
// Purpose: control and protection logic of a multiphase buck controller
// Assumes: analog levels arrive as millivolt samples from converters outside mclk
// Notes on behaviour
// - phase output high, low or tri-state
// - skip output held low during soft-start
// - temperature = (sense - offset) / slope
// - temperature saturates at maximum reportable value
// - sense above fault level turns phases off
// - config bit disables stage fault detection
// - boot-return after delay sets flag, loads boot voltage
// - ramp to boot voltage at selected slew
// - request released high clears boot-return flag
// - lockout turns off; on needs bias and enable
// - two-bit setting selects lockout thresholds
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`include "vrcfl_map.svh"
module vrcfl_top (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// pins and converter samples
	input wire logic [11:0] thermal_sense_input,
	input wire logic [15:0] input_supply,
	input wire logic bias_supply_ok,
	input wire logic enable,
	input wire logic boot_return_req_n,
	input wire logic [1:0] slew_select,
	// phase demand from the regulation loop
	input wire logic [5:0] phase_high_req,
	// power stage outputs
	output logic [5:0] pwm_out,
	output logic [5:0] pwm_oe_n,
	output logic skip_mode_output,
	// status outputs
	output logic [15:0] dac_millivolts,
	output logic dac_valid,
	output logic boot_return_flag,
	output logic stage_fault
);
	////////////////////////////////////////////////////////////////////////////
	// synchronisers
	logic [11:0] thermal_sense_input_s;
	logic [15:0] vin_s;
	logic [4:0] pins_s;
	logic bias_s, en_s, req_n_s;
	logic [1:0] slew_s;

	vrcfl_sync #(.W(12)) u_sync_thermal_sense_input (.mclk(mclk), .resetn(resetn), .d(thermal_sense_input), .q(thermal_sense_input_s));
	vrcfl_sync #(.W(16)) u_sync_vin (.mclk(mclk), .resetn(resetn), .d(input_supply), .q(vin_s));
	vrcfl_sync #(.W(5)) u_sync_pins (.mclk(mclk), .resetn(resetn),
		.d({bias_supply_ok, enable, !boot_return_req_n, slew_select}), .q(pins_s));
	assign bias_s = pins_s[4];
	assign en_s = pins_s[3];
	// request synced active high so the synchroniser's reset value is the idle level
	assign req_n_s = !pins_s[2];
	assign slew_s = pins_s[1:0];

	////////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] ctrl_q;
	logic [7:0] stage_fault_config_q;
	logic [1:0] undervoltage_lockout_select_config_q;
	logic [7:0] boot_voltage_q;
	logic [7:0] output_voltage_target_q;
	logic [7:0] dac_code_q;
	logic [15:0] temp_q;
	logic undervoltage_lockout_ok_q;
	logic boot_set;
	logic [7:0] rdata_d;
	vrcfl_pkg::vrcfl_state_t state_q;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ctrl_q <= `VRCFL_CTRL_RST;
			stage_fault_config_q <= `VRCFL_STAGE_FAULT_RST;
			undervoltage_lockout_select_config_q <= `VRCFL_UNDERVOLTAGE_LOCKOUT_SEL_RST;
			boot_voltage_q <= `VRCFL_BOOT_VOLTAGE_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				`VRCFL_REG_CTRL: ctrl_q <= reg_wdata;
				`VRCFL_REG_STAGE_FAULT_CONFIG: stage_fault_config_q <= reg_wdata;
				`VRCFL_REG_UNDERVOLTAGE_LOCKOUT_SELECT_CONFIG: undervoltage_lockout_select_config_q <= reg_wdata[1:0];
				`VRCFL_REG_BOOT_VOLTAGE: boot_voltage_q <= reg_wdata;
				default: ;
			endcase
		end
	end

	// the boot-return load wins over a software write in the same cycle
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			output_voltage_target_q <= `VRCFL_BOOT_VOLTAGE_RST;
		end else if (boot_set) begin
			output_voltage_target_q <= boot_voltage_q;
		end else if (reg_wr && reg_addr == `VRCFL_REG_OUTPUT_VOLTAGE_TARGET) begin
			output_voltage_target_q <= reg_wdata;
		end
	end

	always_comb begin
		case (reg_addr)
			`VRCFL_REG_CTRL: rdata_d = ctrl_q;
			`VRCFL_REG_STAGE_FAULT_CONFIG: rdata_d = stage_fault_config_q;
			`VRCFL_REG_UNDERVOLTAGE_LOCKOUT_SELECT_CONFIG: rdata_d = {6'h00, undervoltage_lockout_select_config_q};
			`VRCFL_REG_BOOT_VOLTAGE: rdata_d = boot_voltage_q;
			`VRCFL_REG_OUTPUT_VOLTAGE_TARGET: rdata_d = output_voltage_target_q;
			`VRCFL_REG_STATUS: rdata_d = {2'h0, state_q, dac_valid, undervoltage_lockout_ok_q, stage_fault, boot_return_flag};
			`VRCFL_REG_TEMP_LO: rdata_d = temp_q[7:0];
			`VRCFL_REG_TEMP_HI: rdata_d = temp_q[15:8];
			`VRCFL_REG_DAC_CODE: rdata_d = dac_code_q;
			default: rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// temperature, tenths of a degree: (v - offset) * 10 / 8
	logic [15:0] temp_d;
	logic [15:0] thermal_sense_input_excess;

	always_comb begin
		thermal_sense_input_excess = {4'h0, thermal_sense_input_s} - {4'h0, `VRCFL_TEMP_OFFSET_MV};
		if (thermal_sense_input_s <= `VRCFL_TEMP_OFFSET_MV) begin
			temp_d = 16'h0000;
		end else if (16'(({2'h0, thermal_sense_input_excess[13:0]} * 16'h0005) >> 2) >= `VRCFL_TEMP_MAX_TENTHS) begin
			temp_d = `VRCFL_TEMP_MAX_TENTHS;
		end else begin
			temp_d = 16'(({2'h0, thermal_sense_input_excess[13:0]} * 16'h0005) >> 2);
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			temp_q <= 16'h0000;
		end else begin
			temp_q <= temp_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// power stage fault
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			stage_fault <= 1'b0;
		end else begin
			stage_fault <= (thermal_sense_input_s > `VRCFL_STAGE_FAULT_MV) &&
				!stage_fault_config_q[`VRCFL_FAULT_DISABLE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// input undervoltage lockout with hysteresis
	logic [15:0] undervoltage_lockout_on_mv, undervoltage_lockout_off_mv;

	always_comb begin
		case (undervoltage_lockout_select_config_q)
			2'h0: begin
				undervoltage_lockout_on_mv = `VRCFL_UVLO0_ON_MV;
				undervoltage_lockout_off_mv = `VRCFL_UVLO0_OFF_MV;
			end
			2'h1: begin
				undervoltage_lockout_on_mv = `VRCFL_UVLO1_ON_MV;
				undervoltage_lockout_off_mv = `VRCFL_UVLO1_OFF_MV;
			end
			2'h2: begin
				undervoltage_lockout_on_mv = `VRCFL_UVLO2_ON_MV;
				undervoltage_lockout_off_mv = `VRCFL_UVLO2_OFF_MV;
			end
			default: begin
				undervoltage_lockout_on_mv = `VRCFL_UVLO3_ON_MV;
				undervoltage_lockout_off_mv = `VRCFL_UVLO3_OFF_MV;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			undervoltage_lockout_ok_q <= 1'b0;
		end else if (vin_s < undervoltage_lockout_off_mv) begin
			undervoltage_lockout_ok_q <= 1'b0;
		end else if (vin_s > undervoltage_lockout_on_mv) begin
			undervoltage_lockout_ok_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// boot-return request
	logic [7:0] req_cnt_q;

	assign boot_set = !req_n_s && !boot_return_flag && (req_cnt_q == 8'(`VRCFL_BOOT_RETURN_CYCLES - 1));

	always_ff @(posedge mclk) begin
		if (!resetn || req_n_s) begin
			req_cnt_q <= 8'h00;
		end else if (!boot_return_flag) begin
			req_cnt_q <= req_cnt_q + 8'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			boot_return_flag <= 1'b0;
		end else if (boot_set) begin
			boot_return_flag <= 1'b1;
		end else if (req_n_s) begin
			boot_return_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// slew tick divider and dac code ramp
	logic [15:0] slew_cnt_q, slew_period;
	logic slew_tick;
	logic run_ok;

	always_comb begin
		case (slew_s)
			2'h0: slew_period = `VRCFL_SLEW_TICK0;
			2'h1: slew_period = `VRCFL_SLEW_TICK1;
			2'h2: slew_period = `VRCFL_SLEW_TICK2;
			default: slew_period = `VRCFL_SLEW_TICK3;
		endcase
	end

	assign slew_tick = (slew_cnt_q >= slew_period - 16'h0001);
	assign run_ok = undervoltage_lockout_ok_q && bias_s && en_s;

	always_ff @(posedge mclk) begin
		if (!resetn || slew_tick) begin
			slew_cnt_q <= 16'h0000;
		end else begin
			slew_cnt_q <= slew_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn || !run_ok) begin
			dac_code_q <= 8'h00;
		end else if (slew_tick && dac_code_q < output_voltage_target_q) begin
			dac_code_q <= dac_code_q + 8'h01;
		end else if (slew_tick && dac_code_q > output_voltage_target_q) begin
			dac_code_q <= dac_code_q - 8'h01;
		end
	end

	logic [15:0] dec_mv;
	logic dec_valid;

	vrcfl_code_decode u_decode (
		.voltage_code(dac_code_q),
		.coarse_mode(ctrl_q[`VRCFL_CTRL_COARSE_BIT]),
		.millivolts(dec_mv),
		.valid(dec_valid)
	);

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			dac_millivolts <= 16'h0000;
			dac_valid <= 1'b0;
		end else begin
			dac_millivolts <= dec_mv;
			dac_valid <= dec_valid;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// start-up sequence
	always_ff @(posedge mclk) begin
		if (!resetn || !run_ok) begin
			state_q <= vrcfl_pkg::ST_OFF;
		end else begin
			case (state_q)
				vrcfl_pkg::ST_OFF: state_q <= vrcfl_pkg::ST_SOFTSTART;
				vrcfl_pkg::ST_SOFTSTART: begin
					if (dac_code_q == output_voltage_target_q) begin
						state_q <= vrcfl_pkg::ST_RUN;
					end
				end
				vrcfl_pkg::ST_RUN: state_q <= vrcfl_pkg::ST_RUN;
				default: state_q <= vrcfl_pkg::ST_OFF;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			skip_mode_output <= 1'b0;
		end else begin
			skip_mode_output <= (state_q == vrcfl_pkg::ST_RUN);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// phase outputs: tri-state when off, faulted or code invalid
	logic phases_off;

	assign phases_off = (state_q == vrcfl_pkg::ST_OFF) || stage_fault || !dac_valid;

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_phase
			always_ff @(posedge mclk) begin
				if (!resetn || phases_off) begin
					pwm_out[gi] <= 1'b0;
					pwm_oe_n[gi] <= 1'b1;
				end else begin
					pwm_out[gi] <= phase_high_req[gi];
					pwm_oe_n[gi] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule : vrcfl_top

// ### test/vrcfl_stage_model.sv
// Purpose: power stages and load seen from the controller pins
// Assumes: bench sets sense level, fault and request
// Notes: request changes only after a clock edge
`timescale 1ns/10ps
module vrcfl_stage_model (
	// from bench
	input wire logic mclk,
	input wire logic [11:0] sense_mv,
	input wire logic inj_fault,
	input wire logic boot_req,
	// to controller
	output logic [11:0] thermal_sense_input,
	output logic boot_return_req_n = 1'b1
);
	// a failed stage pulls the shared line to its 3.3 V rail
	assign thermal_sense_input = inj_fault ? 12'hCE4 : sense_mv;
	// load holds the request low, drives it high to release
	always_ff @(posedge mclk) begin
		boot_return_req_n <= ~boot_req;
	end
endmodule : vrcfl_stage_model

// ### test/vrcfl_top_assertions.sv
// Purpose: port checker of the control and fault block
// Assumes: mclk domain only
// Notes: bound to vrcfl_top
`timescale 1ns/10ps
module vrcfl_top_checker (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// watched ports
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [11:0] thermal_sense_input,
	input wire logic [15:0] input_supply,
	input wire logic boot_return_req_n,
	input wire logic [5:0] phase_high_req,
	input wire logic [5:0] pwm_out,
	input wire logic [5:0] pwm_oe_n,
	input wire logic skip_mode_output,
	input wire logic dac_valid,
	input wire logic boot_return_flag,
	input wire logic stage_fault
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	a_reset_outputs_safe: assert property ($rose(resetn) |-> pwm_oe_n == 6'h3F && !skip_mode_output && !boot_return_flag)
		else $error("outputs not at reset values");
	a_fault_phases_off: assert property (stage_fault && $past(stage_fault) |-> pwm_oe_n == 6'h3F)
		else $error("phase driven during stage fault");
	a_fault_level_clear: assert property ((thermal_sense_input <= 12'h9C4) [*7] |-> !stage_fault)
		else $error("fault with sense below level");
	a_drive_needs_code: assert property (pwm_oe_n != 6'h3F |-> dac_valid || $past(dac_valid))
		else $error("phase driven with invalid code");
	a_phase_follows_req: assert property (((pwm_out ^ $past(phase_high_req)) & ~pwm_oe_n) == 6'h00)
		else $error("phase level differs from demand");
	a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	a_flag_release: assert property (boot_return_req_n [*6] |-> !boot_return_flag)
		else $error("boot flag kept after release");
	a_flag_min_delay: assert property ($rose(boot_return_flag) |-> !$past(boot_return_req_n, 25) && !$past(boot_return_req_n, 3))
		else $error("boot flag without long request");
	a_lockout_off: assert property ((input_supply < 16'h0DAC) [*8] |-> pwm_oe_n == 6'h3F && !skip_mode_output)
		else $error("running below lockout");
endmodule : vrcfl_top_checker
bind vrcfl_top vrcfl_top_checker u_chk (.mclk, .resetn, .reg_rd, .reg_rdata, .thermal_sense_input, .input_supply,
	.boot_return_req_n, .phase_high_req, .pwm_out, .pwm_oe_n, .skip_mode_output, .dac_valid, .boot_return_flag,
	.stage_fault);

// ### test/vrcfl_top_tb_top.sv
// Purpose: self-checking bench of the control and fault block
// Assumes: inputs change on rising edges only
// Notes: slew setting 0, one code step per 25 cycles, until t_boot selects setting 1 (50 cycles)
`timescale 1ns/10ps
module vrcfl_top_tb_top;
	logic mclk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, bias_supply_ok = 1, enable = 1, boot_req = 0, inj = 0;
	logic [3:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, reg_rdata, d;
	logic [11:0] sense_mv = 12'h3E8, thermal_sense_input;
	logic [15:0] input_supply = 16'h0000, dac_millivolts;
	logic [1:0] slew_select = 2'h0;
	logic [5:0] phase_high_req = 6'h00, pwm_out, pwm_oe_n;
	logic skip_mode_output, dac_valid, boot_return_flag, stage_fault, boot_return_req_n;
	int num_errors = 0, n_tests = 0;
	always #20 mclk = ~mclk;
	vrcfl_top dut (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .thermal_sense_input,
		.input_supply, .bias_supply_ok, .enable, .boot_return_req_n, .slew_select, .phase_high_req, .pwm_out,
		.pwm_oe_n, .skip_mode_output, .dac_millivolts, .dac_valid, .boot_return_flag, .stage_fault);
	vrcfl_stage_model u_stage (.mclk, .sense_mv, .inj_fault(inj), .boot_req, .thermal_sense_input,
		.boot_return_req_n);
	////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		d = reg_rdata;
	endtask : rd
	task automatic wait_mv(input logic [15:0] mv);
		for (int i = 0; i < 4000 && dac_millivolts !== mv; i++) @(posedge mclk);
		@(posedge mclk);
		chk(dac_millivolts, mv, "dac mv");
	endtask : wait_mv
	task automatic temp(input logic [11:0] mv, input logic [15:0] exp);
		@(posedge mclk);
		sense_mv <= mv;
		repeat (6) @(posedge mclk);
		rd(4'h6);
		chk(d, exp[7:0], "temp lo");
		rd(4'h7);
		chk(d, exp[15:8], "temp hi");
	endtask : temp
	////////////////////////////////////////
	task automatic t_regs;
		logic [3:0] a[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hF};
		logic [7:0] e[6] = '{8'h00, 8'h00, 8'h01, 8'h97, 8'h97, 8'h00};
		for (int i = 0; i < 6; i++) begin
			rd(a[i]);
			chk(d, e[i], "reset value");
		end
		$display("t_regs done");
	endtask : t_regs
	task automatic t_power;
		@(posedge mclk);
		input_supply <= 16'h1C53;
		phase_high_req <= 6'h2A;
		for (int i = 0; i < 6000 && skip_mode_output !== 1'b1; i++) begin
			@(posedge mclk);
			if (dac_millivolts !== 16'h03E8) chk(skip_mode_output, 1'b0, "skip in soft-start");
		end
		chk(skip_mode_output, 1'b1, "skip after soft-start");
		chk(dac_millivolts, 16'h03E8, "boot code mv");
		chk(pwm_out, 6'h2A, "phase level");
		chk(pwm_oe_n, 6'h00, "phase driven");
		$display("t_power done");
	endtask : t_power
	task automatic t_fault;
		temp(12'h3E8, 16'h01F4);
		temp(12'h7D0, 16'h04FF);
		temp(12'h3E8, 16'h01F4);
		@(posedge mclk);
		inj <= 1'b1;
		repeat (8) @(posedge mclk);
		chk(stage_fault, 1'b1, "fault seen");
		chk(pwm_oe_n, 6'h3F, "phases off");
		wr(4'h1, 8'h08);
		repeat (8) @(posedge mclk);
		chk(stage_fault, 1'b0, "fault disabled");
		chk(pwm_oe_n, 6'h00, "phases back");
		inj <= 1'b0;
		repeat (6) @(posedge mclk);
		wr(4'h1, 8'h00);
		$display("t_fault done");
	endtask : t_fault
	task automatic t_decode;
		wr(4'h4, 8'hFF);
		wait_mv(16'h05F0);
		wr(4'h4, 8'hC9);
		wait_mv(16'h04E2);
		wr(4'h0, 8'h01);
		wait_mv(16'h09C4);
		wr(4'h4, 8'hCA);
		for (int i = 0; i < 100 && dac_valid !== 1'b0; i++) @(posedge mclk);
		repeat (2) @(posedge mclk);
		chk(dac_valid, 1'b0, "code past last");
		chk(pwm_oe_n, 6'h3F, "no drive past last");
		wr(4'h0, 8'h00);
		wait_mv(16'h04E7);
		$display("t_decode done");
	endtask : t_decode
	task automatic t_boot;
		int n;
		logic [15:0] m;
		wr(4'h3, 8'h80);
		boot_req <= 1'b1;
		repeat (10) @(posedge mclk);
		boot_req <= 1'b0;
		repeat (10) @(posedge mclk);
		chk(boot_return_flag, 1'b0, "short request");
		boot_req <= 1'b1;
		slew_select <= 2'h1;
		for (int i = 0; i < 40 && boot_return_flag !== 1'b1; i++) @(posedge mclk);
		chk(boot_return_flag, 1'b1, "boot flag");
		rd(4'h4);
		chk(d, 8'h80, "target loaded");
		m = dac_millivolts;
		for (int i = 0; i < 200 && dac_millivolts === m; i++) @(posedge mclk);
		m = dac_millivolts;
		n = 0;
		while (n < 200 && dac_millivolts === m) begin
			@(posedge mclk);
			n++;
		end
		chk(16'(n), 16'h0032, "slew step at setting 1");
		wait_mv(16'h0375);
		@(posedge mclk);
		boot_req <= 1'b0;
		repeat (8) @(posedge mclk);
		chk(boot_return_flag, 1'b0, "flag released");
		$display("t_boot done");
	endtask : t_boot
	task automatic t_undervoltage_lockout;
		logic [15:0] on[4] = '{16'h1194, 16'h1C52, 16'h1EDC, 16'h283C};
		logic [15:0] off[4] = '{16'h0DAC, 16'h186A, 16'h1AF4, 16'h2454};
		for (int s = 0; s < 4; s++) begin
			wr(4'h2, 8'(s));
			input_supply <= off[s] - 16'h0001;
			repeat (8) @(posedge mclk);
			chk(pwm_oe_n, 6'h3F, "off below");
			input_supply <= on[s];
			repeat (8) @(posedge mclk);
			chk(skip_mode_output, 1'b0, "off in band");
			rd(4'h5);
			chk(d[2], 1'b0, "lockout held in band");
			@(posedge mclk);
			input_supply <= on[s] + 16'h0001;
			repeat (8) @(posedge mclk);
			rd(4'h5);
			chk(d[5:4], 2'h1, "restarted");
			@(posedge mclk);
			input_supply <= off[s];
			repeat (8) @(posedge mclk);
			rd(4'h5);
			chk(d[2], 1'b1, "on in band");
		end
		$display("t_undervoltage_lockout done");
	endtask : t_undervoltage_lockout
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	////////////////////////////////////////
	initial begin
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		t_regs();
		t_power();
		t_fault();
		t_decode();
		t_boot();
		t_undervoltage_lockout();
		finish_test();
	end
	initial begin
		#(40 * 40000);
		num_errors++;
		$display("ERROR %0t watchdog expired", $time);
		finish_test();
	end
endmodule : vrcfl_top_tb_top
